//--- rtl/bus_master.sv
`include "bus_master_regs.svh"

module bus_master #(
    parameter int REFRESH_CYCLES = `REFRESH_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // user command side
    input wire logic cmd_valid_i,
    input wire bus_master_pkg::cmd_t cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output bus_master_pkg::rsp_t rsp_o,
    input wire logic [1:0] irq_req_i,
    // arbitration
    output logic bus_req_o,
    input wire logic bus_grant_i,
    // backplane lines
    input wire logic slave_reply_i,
    input wire logic [21:0] dal_i,
    output logic [21:0] dal_o,
    output logic [21:0] dal_oe_b_o,
    output logic cycle_sync_strobe_o,
    output logic read_data_in_strobe_o,
    output logic write_data_out_strobe_o,
    output logic write_byte_qual_o,
    output logic refresh_qualifier_o,
    output logic irq_level_five_o,
    output logic irq_level_six_o
);
    import bus_master_pkg::*;

    localparam logic [7:0] TIMEOUT_LAST = 8'(`REPLY_TIMEOUT_CYC - 1);
    localparam logic [15:0] REFRESH_LAST = 16'(REFRESH_CYCLES - 1);

    state_t state;
    cmd_t cur;
    logic refr_cycle;
    logic grant_s;
    logic reply_s;
    logic [21:0] dal_s;
    logic [7:0] wait_cnt;
    logic timed_out;
    logic [15:0] refr_cnt;
    logic refresh_due;
    logic refr_start;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pin_sync #(.W(24)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({bus_grant_i, slave_reply_i, dal_i}),
        .level_o({grant_s, reply_s, dal_s})
    );

    function automatic logic is_read(input cycle_kind_t k);
        return k == word_read_cycle || k == word_rmw_cycle || k == byte_rmw_cycle
            || k == block_read_cycle;
    endfunction : is_read

    function automatic logic is_byte(input cycle_kind_t k);
        return k == byte_write_cycle || k == byte_rmw_cycle;
    endfunction : is_byte

    function automatic logic [15:0] lane(input cmd_t c);
        if (is_byte(c.kind)) begin
            return c.addr[0] ? {c.data[7:0], 8'h00} : {8'h00, c.data[7:0]};
        end
        return c.data;
    endfunction : lane

    // ----------------------------------------
    // reply wait timer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_cnt <= 8'h00;
        end else if (state == s_rd_wait || state == s_wr_wait || state == s_rd_end
                || state == s_wr_end) begin
            if (reply_s != (state == s_rd_end || state == s_wr_end)) begin
                wait_cnt <= 8'h00;
            end else begin
                wait_cnt <= wait_cnt + 8'h01;
            end
        end else begin
            wait_cnt <= 8'h00;
        end
    end
    assign timed_out = (wait_cnt == TIMEOUT_LAST);

    // ----------------------------------------
    // refresh interval timer
    // ----------------------------------------
    assign refr_start = (state == s_idle) && refresh_due && !(cmd_ready_o && cmd_valid_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            refr_cnt <= 16'h0000;
            refresh_due <= 1'b0;
        end else begin
            if (refr_cnt == REFRESH_LAST) begin
                refr_cnt <= 16'h0000;
                refresh_due <= 1'b1;
            end else begin
                refr_cnt <= refr_cnt + 16'h0001;
                if (refr_start) begin
                    refresh_due <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // interrupt request lines
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_level_five_o <= 1'b0;
            irq_level_six_o <= 1'b0;
        end else begin
            irq_level_five_o <= irq_req_i[0];
            irq_level_six_o <= irq_req_i[1];
        end
    end

    // ----------------------------------------
    // cycle sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= s_idle;
            cur <= '0;
            refr_cycle <= 1'b0;
            cmd_ready_o <= 1'b1;
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
            bus_req_o <= 1'b0;
            dal_o <= 22'h000000;
            dal_oe_b_o <= 22'h3fffff;
            cycle_sync_strobe_o <= 1'b0;
            read_data_in_strobe_o <= 1'b0;
            write_data_out_strobe_o <= 1'b0;
            write_byte_qual_o <= 1'b0;
            refresh_qualifier_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            unique case (state)
                s_idle: begin
                    if (cmd_ready_o && cmd_valid_i) begin
                        cur <= cmd_i;
                        refr_cycle <= 1'b0;
                        rsp_o <= '0;
                        cmd_ready_o <= 1'b0;
                        state <= s_req;
                    end else if (refresh_due) begin
                        cur <= '0;
                        refr_cycle <= 1'b1;
                        cmd_ready_o <= 1'b0;
                        state <= s_req;
                    end
                end
                s_req: begin
                    bus_req_o <= 1'b1;
                    if (grant_s && !reply_s && !cycle_sync_strobe_o) begin
                        bus_req_o <= 1'b0;
                        dal_o <= cur.addr;
                        dal_oe_b_o <= 22'h000000;
                        write_byte_qual_o <= !is_read(cur.kind) && !refr_cycle;
                        refresh_qualifier_o <= refr_cycle;
                        state <= s_addr;
                    end
                end
                s_addr: begin
                    cycle_sync_strobe_o <= 1'b1;
                    state <= s_ahold;
                end
                s_ahold: begin
                    dal_oe_b_o <= 22'h3fffff;
                    write_byte_qual_o <= is_byte(cur.kind);
                    if (is_read(cur.kind) || refr_cycle) begin
                        read_data_in_strobe_o <= 1'b1;
                        state <= s_rd_wait;
                    end else begin
                        dal_o <= {6'h00, lane(cur)};
                        dal_oe_b_o <= 22'h3f0000;
                        state <= s_wr_set;
                    end
                end
                s_rd_wait: begin
                    if (reply_s) begin
                        rsp_o.data <= dal_s[15:0];
                        rsp_o.mem_err <= dal_s[`ERR_DATA_BIT] & dal_s[`ERR_EN_BIT];
                        read_data_in_strobe_o <= 1'b0;
                        state <= s_rd_end;
                    end else if (timed_out) begin
                        rsp_o.timeout <= 1'b1;
                        read_data_in_strobe_o <= 1'b0;
                        state <= s_term;
                    end
                end
                s_rd_end: begin
                    if (timed_out) begin
                        rsp_o.timeout <= 1'b1;
                        state <= s_term;
                    end else if (!reply_s) begin
                        if (!refr_cycle && (cur.kind == word_rmw_cycle
                                || cur.kind == byte_rmw_cycle)) begin
                            dal_o <= {6'h00, lane(cur)};
                            dal_oe_b_o <= 22'h3f0000;
                            state <= s_wr_set;
                        end else if (!refr_cycle && cur.kind == block_read_cycle
                                && !cur.last) begin
                            rsp_valid_o <= 1'b1;
                            cmd_ready_o <= 1'b1;
                            state <= s_blk_wait;
                        end else begin
                            state <= s_term;
                        end
                    end
                end
                s_wr_set: begin
                    write_data_out_strobe_o <= 1'b1;
                    state <= s_wr_wait;
                end
                s_wr_wait: begin
                    if (reply_s || timed_out) begin
                        rsp_o.timeout <= !reply_s;
                        write_data_out_strobe_o <= 1'b0;
                        state <= reply_s ? s_wr_end : s_term;
                    end
                end
                s_wr_end: begin
                    if (timed_out) begin
                        rsp_o.timeout <= 1'b1;
                        state <= s_term;
                    end else if (!reply_s) begin
                        dal_oe_b_o <= 22'h3fffff;
                        if (cur.kind == block_write_cycle && !cur.last) begin
                            rsp_valid_o <= 1'b1;
                            cmd_ready_o <= 1'b1;
                            state <= s_blk_wait;
                        end else begin
                            state <= s_term;
                        end
                    end
                end
                s_blk_wait: begin
                    if (cmd_valid_i) begin
                        cmd_ready_o <= 1'b0;
                        cur.data <= cmd_i.data;
                        cur.last <= cmd_i.last;
                        rsp_o <= '0;
                        if (cur.kind == block_read_cycle) begin
                            read_data_in_strobe_o <= 1'b1;
                            state <= s_rd_wait;
                        end else begin
                            dal_o <= {6'h00, cmd_i.data};
                            dal_oe_b_o <= 22'h3f0000;
                            state <= s_wr_set;
                        end
                    end
                end
                s_term: begin
                    cycle_sync_strobe_o <= 1'b0;
                    dal_oe_b_o <= 22'h3fffff;
                    write_byte_qual_o <= 1'b0;
                    refresh_qualifier_o <= 1'b0;
                    rsp_valid_o <= !refr_cycle;
                    cmd_ready_o <= 1'b1;
                    state <= s_idle;
                end
                default: begin
                    state <= s_idle;
                end
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_grant_before_sync:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cycle_sync_strobe_o) |-> $past(grant_s, 2))
        else $error("sync strobe raised without bus grant");

    chk_idle_before_start:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cycle_sync_strobe_o) |-> $past(!reply_s, 2))
        else $error("cycle started while reply still asserted");

    chk_addr_before_data:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cycle_sync_strobe_o) |-> dal_oe_b_o == 22'h000000 ##1 dal_oe_b_o[17:16] == 2'b11)
        else $error("address phase not held across sync edge");

    chk_strobe_in_cycle:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (read_data_in_strobe_o || write_data_out_strobe_o) |-> cycle_sync_strobe_o)
        else $error("data strobe outside sync strobe");

    chk_read_lines_free:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        read_data_in_strobe_o |-> dal_oe_b_o == 22'h3fffff)
        else $error("lines driven during read data phase");

    chk_write_data_setup:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(write_data_out_strobe_o) |-> $past(dal_oe_b_o[15:0]) == 16'h0000
            && dal_o[15:0] == lane(cur))
        else $error("write strobe without data set up");

    chk_rmw_locked:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (state == s_rd_end && !reply_s && !timed_out && !refr_cycle
            && (cur.kind == word_rmw_cycle || cur.kind == byte_rmw_cycle))
        |=> state == s_wr_set && cycle_sync_strobe_o ##1 write_data_out_strobe_o)
        else $error("rmw write-back not locked under sync");

    chk_block_hold:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state == s_blk_wait |-> cycle_sync_strobe_o && cmd_ready_o)
        else $error("block sequence dropped sync");

    chk_err_lines_free:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (read_data_in_strobe_o || write_data_out_strobe_o) |-> dal_oe_b_o[17:16] == 2'b11)
        else $error("error lines driven in data phase");

    chk_ext_addr_bits:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cycle_sync_strobe_o) |-> dal_o[17:16] == cur.addr[17:16])
        else $error("extended address bits wrong at sync");

    chk_irq_follow:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        irq_req_i == 2'b10 |=> irq_level_six_o && !irq_level_five_o)
        else $error("irq level lines do not follow request");

    chk_refresh_read_only:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        refresh_qualifier_o |-> !write_data_out_strobe_o && !rsp_valid_o)
        else $error("refresh qualifier on a write or reported cycle");

endmodule : bus_master

//--- include/bus_master_regs.svh
// Notes on behaviour
// - a master gets the bus through processor arbitration before driving any cycle.
// - first cycle starts only once sync strobe and slave reply are both negated.
// - every cycle runs address phase, then data phase, then termination.
// - word read, word write and byte write cycles are supported.
// - locked read-modify-write: read a word, write back word or byte.
// - block read and block write move successive words in one addressing sequence.
// - line 16 is address bit, then memory-error data in data phase.
// - line 17 is address bit, then memory-error logic enable in data phase.
// - interrupt requesters use the level-five and level-six request lines.
// - masters avoid long bursts so refresh completes at least every 1.6 ms; here a due refresh waits behind any command or block sequence.
`ifndef BUS_MASTER_REGS_SVH
`define BUS_MASTER_REGS_SVH

// ----------------------------------------
// widths and line positions
// ----------------------------------------
`define ADDR_W 22
`define DATA_W 16
`define ERR_DATA_BIT 16
`define ERR_EN_BIT 17

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define REPLY_TIMEOUT_NS 10000
`define REPLY_TIMEOUT_CYC (`REPLY_TIMEOUT_NS / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_US 1600
`define REFRESH_CYC ((`REFRESH_PERIOD_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- include/bus_master_pkg.sv
package bus_master_pkg;

    typedef enum logic [2:0] {
        word_read_cycle = 3'h0,
        word_write_cycle = 3'h1,
        byte_write_cycle = 3'h2,
        word_rmw_cycle = 3'h3,
        byte_rmw_cycle = 3'h4,
        block_read_cycle = 3'h5,
        block_write_cycle = 3'h6
    } cycle_kind_t;

    typedef enum logic [3:0] {
        s_idle = 4'h0,
        s_req = 4'h1,
        s_addr = 4'h2,
        s_ahold = 4'h3,
        s_rd_wait = 4'h4,
        s_rd_end = 4'h5,
        s_wr_set = 4'h6,
        s_wr_wait = 4'h7,
        s_wr_end = 4'h8,
        s_blk_wait = 4'h9,
        s_term = 4'ha
    } state_t;

    typedef struct packed {
        cycle_kind_t kind;
        logic [21:0] addr;
        logic [15:0] data;
        logic last;
    } cmd_t;

    typedef struct packed {
        logic [15:0] data;
        logic mem_err;
        logic timeout;
    } rsp_t;

endpackage : bus_master_pkg

//--- rtl/pin_sync.sv
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // pins in, settled copy out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    // ----------------------------------------
    // three stages, change taken when two agree
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            level_o <= '0;
        end else begin
            ff1 <= pin_i;
            ff2 <= ff1;
            ff3 <= ff2;
            for (int i = 0; i < W; i++) begin
                if (ff2[i] == ff3[i]) begin
                    level_o[i] <= ff3[i];
                end
            end
        end
    end

endmodule : pin_sync

//--- dv/mem_slave_model.sv
module mem_slave_model #(
    parameter logic [21:0] START_ADDR = 22'h030000,
    parameter logic [21:0] END_ADDR = 22'h0301ff
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // master strobes
    input wire logic sync_i,
    input wire logic din_i,
    input wire logic dout_i,
    input wire logic byte_i,
    input wire logic ref_i,
    input wire logic [21:0] dal_i,
    // slave drive
    output logic reply_o,
    output logic [21:0] dal_o,
    output logic [21:0] dal_en_o,
    // scenario control
    input wire logic [7:0] delay_i,
    input wire logic err_i,
    output logic [15:0] refresh_count_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // slave only: never drives sync or strobes
    // ----------------------------------------
    logic [15:0] mem [256];
    logic [21:0] addr;
    logic [21:0] a;
    logic hit;
    logic sync_q;
    logic strobe_q;
    logic [1:0] kind_q;
    logic [7:0] wait_cnt;

    // same kind again in one sequence moves to the next word
    assign a = (kind_q == {din_i, dout_i}) ? addr + 22'h2 : addr;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reply_o <= 1'b0;
            dal_en_o <= '0;
            dal_o <= '0;
            wait_cnt <= '0;
            sync_q <= 1'b0;
            strobe_q <= 1'b0;
            kind_q <= 2'h0;
            hit <= 1'b0;
            refresh_count_o <= '0;
        end else begin
            sync_q <= sync_i;
            strobe_q <= din_i | dout_i;
            if (sync_i && !sync_q) begin
                addr <= dal_i;
                hit <= (dal_i >= START_ADDR) && (dal_i <= END_ADDR);
                kind_q <= 2'h0;
            end
            if (ref_i && sync_i && din_i && !strobe_q) begin
                refresh_count_o <= refresh_count_o + 16'h1;
            end
            if (!(din_i | dout_i)) begin
                reply_o <= 1'b0;
                dal_en_o <= '0;
                wait_cnt <= '0;
            end else if (sync_i && hit && !reply_o) begin
                if (wait_cnt < delay_i) begin
                    wait_cnt <= wait_cnt + 8'h1;
                end else begin
                    reply_o <= 1'b1;
                    addr <= a;
                    kind_q <= {din_i, dout_i};
                    if (din_i) begin
                        dal_o <= {4'h0, err_i, err_i, mem[a[8:1]]};
                        dal_en_o <= {4'h0, err_i, err_i, 16'hffff};
                    end else if (byte_i && a[0]) begin
                        mem[a[8:1]][15:8] <= dal_i[15:8];
                    end else if (byte_i) begin
                        mem[a[8:1]][7:0] <= dal_i[7:0];
                    end else begin
                        mem[a[8:1]] <= dal_i[15:0];
                    end
                end
            end
        end
    end
endmodule : mem_slave_model

//--- dv/bus_master_tb.sv
module bus_master_tb import bus_master_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [21:0] A = 22'h030010;
    localparam logic [21:0] B = 22'h030100;
    logic clk_i;
    logic rst_b_i;
    logic cmd_valid_i;
    cmd_t cmd_i;
    logic cmd_ready_o, rsp_valid_o, bus_req_o, reply;
    rsp_t rsp_o;
    rsp_t got;
    logic [1:0] irq_req_i;
    logic bus_grant_i = 1'b0;
    logic [21:0] dal_o, dal_oe_b_o, m_dal, m_en, dal_w;
    logic sync, din, dout, byte_q, refq, irq5, irq6;
    logic [7:0] delay;
    logic err;
    logic [15:0] ref_cnt;
    int bad_count = 0;
    int samples_checked = 0;

    // terminated lines read negated when nobody drives
    assign dal_w = (~dal_oe_b_o & dal_o) | (dal_oe_b_o & m_en & m_dal);

    bus_master #(.REFRESH_CYCLES(200)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
        .irq_req_i(irq_req_i), .bus_req_o(bus_req_o), .bus_grant_i(bus_grant_i),
        .slave_reply_i(reply), .dal_i(dal_w), .dal_o(dal_o), .dal_oe_b_o(dal_oe_b_o),
        .cycle_sync_strobe_o(sync), .read_data_in_strobe_o(din),
        .write_data_out_strobe_o(dout), .write_byte_qual_o(byte_q),
        .refresh_qualifier_o(refq), .irq_level_five_o(irq5), .irq_level_six_o(irq6)
    );

    mem_slave_model partner (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .sync_i(sync), .din_i(din), .dout_i(dout),
        .byte_i(byte_q), .ref_i(refq), .dal_i(dal_w), .reply_o(reply), .dal_o(m_dal),
        .dal_en_o(m_en), .delay_i(delay), .err_i(err), .refresh_count_o(ref_cnt)
    );

    // ----------------------------------------
    // clock, arbitration, watchdog
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(negedge clk_i) begin
        if (!bus_req_o) begin
            bus_grant_i <= 1'b0;
        end else if (!reply && !sync) begin
            bus_grant_i <= 1'b1;
        end
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input cycle_kind_t k, input logic [21:0] a, input logic [15:0] d,
                        input logic l);
        int n;
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_i = '{kind: k, addr: a, data: d, last: l};
        while (cmd_ready_o !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 600) begin
            @(negedge clk_i);
            n++;
        end
        got = rsp_o;
        check(24'(n < 600), 24'h1);
    endtask : xfer

    task automatic rd(input logic [21:0] a, input logic [15:0] exp);
        xfer(word_read_cycle, a, 16'h0, 1'b1);
        check({6'h0, got.timeout, got.mem_err, got.data}, {8'h0, exp});
    endtask : rd

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(24'(cmd_ready_o), 24'h1);
        check({2'h0, dal_oe_b_o}, 24'h3fffff);
        check({18'h0, sync, din, dout, bus_req_o, irq5, irq6}, 24'h0);
    endtask : t_reset

    task automatic t_word();
        xfer(word_write_cycle, A, 16'h1234, 1'b1);
        rd(A, 16'h1234);
        delay = 8'd20;
        rd(A, 16'h1234);
        delay = 8'd0;
    endtask : t_word

    task automatic t_byte();
        xfer(word_write_cycle, A + 22'h2, 16'haaaa, 1'b1);
        xfer(byte_write_cycle, A + 22'h3, 16'h005c, 1'b1);
        xfer(byte_write_cycle, A + 22'h2, 16'h0033, 1'b1);
        rd(A + 22'h2, 16'h5c33);
    endtask : t_byte

    task automatic t_rmw();
        xfer(word_rmw_cycle, A, 16'h0f0f, 1'b1);
        check({8'h0, got.data}, 24'h1234);
        rd(A, 16'h0f0f);
        xfer(byte_rmw_cycle, A + 22'h1, 16'h0077, 1'b1);
        check({8'h0, got.data}, 24'h0f0f);
        rd(A, 16'h770f);
    endtask : t_rmw

    task automatic t_block();
        xfer(block_write_cycle, B, 16'h1111, 1'b0);
        xfer(block_write_cycle, B, 16'h2222, 1'b0);
        xfer(block_write_cycle, B, 16'h3333, 1'b1);
        rd(B + 22'h4, 16'h3333);
        xfer(block_read_cycle, B, 16'h0, 1'b0);
        check({8'h0, got.data}, 24'h1111);
        xfer(block_read_cycle, B, 16'h0, 1'b1);
        check({8'h0, got.data}, 24'h2222);
    endtask : t_block

    task automatic t_range_err();
        xfer(word_read_cycle, 22'h000010, 16'h0, 1'b1);
        check(24'(got.timeout), 24'h1);
        err = 1'b1;
        xfer(word_read_cycle, A, 16'h0, 1'b1);
        check({22'h0, got.mem_err, got.timeout}, 24'h2);
        err = 1'b0;
    endtask : t_range_err

    task automatic t_refresh();
        logic [15:0] c0;
        c0 = ref_cnt;
        repeat (450) @(negedge clk_i);
        check(24'(ref_cnt > c0), 24'h1);
    endtask : t_refresh

    task automatic t_irq();
        @(negedge clk_i);
        irq_req_i = 2'b01;
        @(negedge clk_i);
        check({22'h0, irq6, irq5}, 24'h1);
        irq_req_i = 2'b10;
        @(negedge clk_i);
        check({22'h0, irq6, irq5}, 24'h2);
        irq_req_i = 2'b00;
    endtask : t_irq

    initial begin
        rst_b_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_i = '0;
        irq_req_i = 2'b00;
        delay = 8'd0;
        err = 1'b0;
        repeat (2) @(negedge clk_i);
        t_reset();
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        t_word();
        t_byte();
        t_rmw();
        t_block();
        t_range_err();
        t_refresh();
        t_irq();
        print_verdict();
    end
endmodule : bus_master_tb
